// [design/basc_defines.vh]
// Register map, field positions, reset values and timing counts of the serial controller
`ifndef BASC_DEFINES_VH
`define BASC_DEFINES_VH
// Register addresses
`define BASC_A_DATA 3'h0
`define BASC_A_AUX 3'h1
`define BASC_A_BANK 3'h2
`define BASC_A_LINE 3'h3
`define BASC_A_MODE 3'h4
`define BASC_A_STAT 3'h5
`define BASC_A_MDM 3'h6
`define BASC_A_GEN 3'h7
// Banks
`define BASC_B0 2'h0
`define BASC_B1 2'h1
`define BASC_B2 2'h2
`define BASC_B3 2'h3
// Slots of the plain read/write registers
`define BASC_NCFG 21
`define BASC_S_ADDRESS_CHAR_ZERO 5'h00
`define BASC_S_ADDRESS_CHAR_ONE 5'h01
`define BASC_S_BAUD_GEN_A_CONFIG 5'h02
`define BASC_S_BAH 5'h03
`define BASC_S_BAL 5'h04
`define BASC_S_BAUD_GEN_B_CONFIG 5'h05
`define BASC_S_BBH 5'h06
`define BASC_S_BBL 5'h07
`define BASC_S_CLOCK_CONFIGURATION 5'h08
`define BASC_S_FMD 5'h09
`define BASC_S_GER 5'h0a
`define BASC_S_IMD 5'h0b
`define BASC_S_LCR 5'h0c
`define BASC_S_MCR 5'h0d
`define BASC_S_MIE 5'h0e
`define BASC_S_MSR 5'h0f
`define BASC_S_PMD 5'h10
`define BASC_S_RIE 5'h11
`define BASC_S_RMD 5'h12
`define BASC_S_TMD 5'h13
`define BASC_S_TIMER_INTERRUPT_ENABLE 5'h14
// Reset values
`define BASC_R_BAL 8'h02
`define BASC_R_BBL 8'h05
`define BASC_R_BAUD_GEN_A_CONFIG 8'h04
`define BASC_R_BAUD_GEN_B_CONFIG 8'h84
`define BASC_R_IMD 8'h0c
`define BASC_R_MIE 8'h0f
`define BASC_R_PMD 8'hfc
`define BASC_R_RIE 8'h1e
`define BASC_R_ZERO 8'h00
`define BASC_R_TIMER_STATUS 8'h30
// Field positions
`define BASC_LCR_DLS 7
`define BASC_LCR_STOP2 2
`define BASC_LCR_PAREN 3
`define BASC_LCR_EVEN 4
`define BASC_BANK_LO 5
`define BASC_MCR_LOOP 4
`define BASC_MCR_ECHO 5
`define BASC_TMD_NINE 0
`define BASC_TMD_MARK 1
`define BASC_RMD_ADDR 0
`define BASC_RMD_CTRL 1
`define BASC_CLOCK_CONFIGURATION_RXB 0
`define BASC_CLOCK_CONFIGURATION_TXB 1
`define BASC_GER_RX 0
`define BASC_GER_TX 1
`define BASC_GER_ERR 2
// Timing: last sample index of a bit and mid-bit point
`define BASC_OVS 4'hf
`define BASC_MID 4'h7
`endif

// [design/basc_top.v]
// Banked asynchronous serial controller with transmit and receive FIFOs
`timescale 1ns/1ps
`include "basc_defines.vh"

// ********************************
// FIFO with programmable usable depth
// ********************************
module basc_fifo #(
  parameter W = 11,
  parameter D = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst,
  // Control
  input wire i_flush,
  input wire [AW:0] i_limit,
  // Fill side
  input wire i_valid,
  output wire o_ready,
  input wire [W-1:0] i_data,
  // Drain side
  output wire o_valid,
  input wire i_ready,
  output wire [W-1:0] o_data,
  output wire [AW:0] o_level
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign o_ready = cnt_q < i_limit;
  assign o_valid = cnt_q != {(AW+1){1'b0}};
  assign o_data = mem[rp_q];
  assign o_level = cnt_q;
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;
  always @(posedge i_mclk) begin
    if (push) begin
      mem[wp_q] <= i_data;
    end
  end
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (i_flush) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// Overview of operation
// - Transmit FIFO four by eleven, depth one-four
// - Transmit engine shifts frames out LSB first
// - Receiver samples, frames, stores into FIFO
// - Three-bit address, eight-bit data bus decode
// - Act only with select and strobe low
// - Interrupt output follows enabled service requests
// - Address two selects bank, reads interrupt
// - Bank zero latch select reaches divisor A
// - Banks zero (latch select clear) and one: address zero reads receive, writes transmit
// - Bank three address zero: divisor B, clock
// - Character lengths five to nine bits
// - Two baud generators derive bit timing
// - Programmable FIFO thresholds raise service requests
// - Automatic echo and internal loopback modes
// - Address match, control char, parity, stops
// - Bank zero offers legacy register model
// - Reset loads documented register defaults
module basc_top (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst,
  // Host bus
  input wire [2:0] i_addr,
  input wire [7:0] i_data,
  output reg [7:0] o_data_q,
  output reg o_data_oe_q,
  input wire i_read_strobe_low,
  input wire i_write_strobe_low,
  input wire i_select_low,
  output reg o_irq_q,
  // Serial line
  input wire i_rxd,
  output reg o_txd_q
);
  localparam TX_IDLE = 2'b01;
  localparam TX_SHIFT = 2'b10;
  localparam RX_IDLE = 4'b0001;
  localparam RX_START = 4'b0010;
  localparam RX_BITS = 4'b0100;
  localparam RX_DONE = 4'b1000;

  // ********************************
  // Register decode
  // ********************************
  function [5:0] cfg_map;
    input [5:0] key;
    begin
      casez (key)
        {`BASC_B0, `BASC_A_GEN, 1'b?}: cfg_map = {1'b1, `BASC_S_ADDRESS_CHAR_ZERO};
        {`BASC_B2, `BASC_A_STAT, 1'b?}: cfg_map = {1'b1, `BASC_S_ADDRESS_CHAR_ONE};
        {`BASC_B3, `BASC_A_AUX, 1'b0}: cfg_map = {1'b1, `BASC_S_BAUD_GEN_A_CONFIG};
        {`BASC_B0, `BASC_A_AUX, 1'b1}: cfg_map = {1'b1, `BASC_S_BAH};
        {`BASC_B0, `BASC_A_DATA, 1'b1}: cfg_map = {1'b1, `BASC_S_BAL};
        {`BASC_B3, `BASC_A_LINE, 1'b?}: cfg_map = {1'b1, `BASC_S_BAUD_GEN_B_CONFIG};
        {`BASC_B3, `BASC_A_AUX, 1'b1}: cfg_map = {1'b1, `BASC_S_BBH};
        {`BASC_B3, `BASC_A_DATA, 1'b1}: cfg_map = {1'b1, `BASC_S_BBL};
        {`BASC_B3, `BASC_A_DATA, 1'b0}: cfg_map = {1'b1, `BASC_S_CLOCK_CONFIGURATION};
        {`BASC_B2, `BASC_A_AUX, 1'b?}: cfg_map = {1'b1, `BASC_S_FMD};
        {`BASC_B0, `BASC_A_AUX, 1'b0}: cfg_map = {1'b1, `BASC_S_GER};
        {`BASC_B2, `BASC_A_MODE, 1'b?}: cfg_map = {1'b1, `BASC_S_IMD};
        {`BASC_B0, `BASC_A_LINE, 1'b?}: cfg_map = {1'b1, `BASC_S_LCR};
        {`BASC_B0, `BASC_A_MODE, 1'b?}: cfg_map = {1'b1, `BASC_S_MCR};
        {`BASC_B1, `BASC_A_MODE, 1'b?}: cfg_map = {1'b1, `BASC_S_MCR};
        {`BASC_B3, `BASC_A_STAT, 1'b?}: cfg_map = {1'b1, `BASC_S_MIE};
        {`BASC_B0, `BASC_A_MDM, 1'b?}: cfg_map = {1'b1, `BASC_S_MSR};
        {`BASC_B1, `BASC_A_MDM, 1'b?}: cfg_map = {1'b1, `BASC_S_MSR};
        {`BASC_B3, `BASC_A_MODE, 1'b?}: cfg_map = {1'b1, `BASC_S_PMD};
        {`BASC_B2, `BASC_A_MDM, 1'b?}: cfg_map = {1'b1, `BASC_S_RIE};
        {`BASC_B2, `BASC_A_GEN, 1'b?}: cfg_map = {1'b1, `BASC_S_RMD};
        {`BASC_B2, `BASC_A_LINE, 1'b?}: cfg_map = {1'b1, `BASC_S_TMD};
        {`BASC_B3, `BASC_A_MDM, 1'b?}: cfg_map = {1'b1, `BASC_S_TIMER_INTERRUPT_ENABLE};
        default: cfg_map = 6'h00;
      endcase
    end
  endfunction

  function [7:0] cfg_reset;
    input integer idx;
    begin
      case (idx)
        `BASC_S_BAL: cfg_reset = `BASC_R_BAL;
        `BASC_S_BBL: cfg_reset = `BASC_R_BBL;
        `BASC_S_BAUD_GEN_A_CONFIG: cfg_reset = `BASC_R_BAUD_GEN_A_CONFIG;
        `BASC_S_BAUD_GEN_B_CONFIG: cfg_reset = `BASC_R_BAUD_GEN_B_CONFIG;
        `BASC_S_IMD: cfg_reset = `BASC_R_IMD;
        `BASC_S_MIE: cfg_reset = `BASC_R_MIE;
        `BASC_S_PMD: cfg_reset = `BASC_R_PMD;
        `BASC_S_RIE: cfg_reset = `BASC_R_RIE;
        default: cfg_reset = `BASC_R_ZERO;
      endcase
    end
  endfunction

  // ********************************
  // Host access tracking
  // ********************************
  reg rd_act_q;
  reg wr_act_q;
  reg [2:0] r_addr_q;
  reg [2:0] w_addr_q;
  reg [7:0] w_data_q;
  reg [1:0] bank_q;
  reg [7:0] cfg_q [0:`BASC_NCFG-1];
  wire rd_act = ~i_select_low & ~i_read_strobe_low;
  wire wr_act = ~i_select_low & ~i_write_strobe_low;
  // Side effects land when the strobe ends, once address and data have settled
  wire rd_done = rd_act_q & ~rd_act;
  wire wr_done = wr_act_q & ~wr_act;
  wire dls = cfg_q[`BASC_S_LCR][`BASC_LCR_DLS];
  wire [5:0] r_map = cfg_map({bank_q, i_addr, dls});
  wire [5:0] w_map = cfg_map({bank_q, w_addr_q, dls});
  wire [4:0] bb = {bank_q, w_addr_q} & 5'h1f;
  wire w_data_port = (w_addr_q == `BASC_A_DATA) & ((bank_q == `BASC_B0) & ~dls | (bank_q == `BASC_B1));
  wire w_mark_port = bb == {`BASC_B1, `BASC_A_AUX};
  wire w_cmd = (bank_q == `BASC_B1) & (w_addr_q != `BASC_A_MODE) & ~w_data_port & ~w_mark_port;
  wire r_data_port = (r_addr_q == `BASC_A_DATA) & ((bank_q == `BASC_B0) & ~dls | (bank_q == `BASC_B1));
  wire r_lsr = {bank_q, r_addr_q} == {`BASC_B0, `BASC_A_STAT};
  wire r_rst = {bank_q, r_addr_q} == {`BASC_B1, `BASC_A_STAT};
  wire rcm_wr = wr_done & ({bank_q, w_addr_q} == {`BASC_B1, `BASC_A_STAT});
  wire tcm_wr = wr_done & ({bank_q, w_addr_q} == {`BASC_B1, `BASC_A_MDM});

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      r_addr_q <= 3'h0;
      w_addr_q <= 3'h0;
      w_data_q <= 8'h00;
      bank_q <= `BASC_B0;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      if (rd_act) begin
        r_addr_q <= i_addr;
      end
      if (wr_act) begin
        w_addr_q <= i_addr;
        w_data_q <= i_data;
      end
      if (wr_done & (w_addr_q == `BASC_A_BANK)) begin
        bank_q <= w_data_q[`BASC_BANK_LO+1:`BASC_BANK_LO];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `BASC_NCFG; gi = gi + 1) begin : g_cfg
      always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          cfg_q[gi] <= cfg_reset(gi);
        end else if (wr_done & w_map[5] & (w_map[4:0] == gi) & ~w_cmd
                     & (w_addr_q != `BASC_A_BANK)) begin
          cfg_q[gi] <= w_data_q;
        end
      end
    end
  endgenerate

  // ********************************
  // Baud generators
  // ********************************
  wire [15:0] div_w [0:1];
  wire [1:0] tick_w;
  assign div_w[0] = {cfg_q[`BASC_S_BAH], cfg_q[`BASC_S_BAL]};
  assign div_w[1] = {cfg_q[`BASC_S_BBH], cfg_q[`BASC_S_BBL]};
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_baud
      reg [15:0] cnt_q;
      // A divisor of zero behaves as one
      assign tick_w[gi] = (cnt_q + 16'h0001) >= div_w[gi];
      always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          cnt_q <= 16'h0000;
        end else if (tick_w[gi]) begin
          cnt_q <= 16'h0000;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  endgenerate
  wire tx_tick = tick_w[cfg_q[`BASC_S_CLOCK_CONFIGURATION][`BASC_CLOCK_CONFIGURATION_TXB]];
  wire rx_tick = tick_w[cfg_q[`BASC_S_CLOCK_CONFIGURATION][`BASC_CLOCK_CONFIGURATION_RXB]];

  // ********************************
  // Character format
  // ********************************
  wire [7:0] line_control = cfg_q[`BASC_S_LCR];
  wire par_en = line_control[`BASC_LCR_PAREN];
  wire [3:0] nbits = cfg_q[`BASC_S_TMD][`BASC_TMD_NINE] ? 4'h9 : 4'h5 + {2'b00, line_control[1:0]};
  // Frame length: start, data, optional parity, one or two stops
  wire [3:0] tx_len = 4'h2 + nbits + {3'h0, par_en} + {3'h0, line_control[`BASC_LCR_STOP2]};
  wire [3:0] rx_len = 4'h1 + nbits + {3'h0, par_en};

  // ********************************
  // FIFOs
  // ********************************
  wire [10:0] txf_q;
  wire txf_valid;
  wire txf_ready;
  wire [2:0] txf_level;
  wire [10:0] rxf_q;
  wire rxf_valid;
  wire rxf_ready;
  wire [2:0] rxf_level;
  wire tx_pop;
  reg rx_push;
  reg [10:0] rx_word;
  wire [8:0] tx_word = {w_mark_port | cfg_q[`BASC_S_TMD][`BASC_TMD_MARK], w_data_q};
  wire tx_push = wr_done & (w_data_port | w_mark_port);
  wire rx_pop = rd_done & r_data_port;

  basc_fifo #(.W(11), .D(4), .AW(2)) u_txf (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_flush(tcm_wr),
    .i_limit({1'b0, cfg_q[`BASC_S_TMD][7:6]} + 3'h1),
    .i_valid(tx_push),
    .o_ready(txf_ready),
    .i_data({2'b00, tx_word}),
    .o_valid(txf_valid),
    .i_ready(tx_pop),
    .o_data(txf_q),
    .o_level(txf_level)
  );

  basc_fifo #(.W(11), .D(4), .AW(2)) u_rxf (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_flush(rcm_wr),
    .i_limit({1'b0, cfg_q[`BASC_S_RMD][7:6]} + 3'h1),
    .i_valid(rx_push),
    .o_ready(rxf_ready),
    .i_data(rx_word),
    .o_valid(rxf_valid),
    .i_ready(rx_pop),
    .o_data(rxf_q),
    .o_level(rxf_level)
  );

  // ********************************
  // Transmit engine
  // ********************************
  reg [1:0] tx_st_q;
  reg [12:0] tx_sh_q;
  reg [3:0] tx_left_q;
  reg [3:0] tx_ph_q;
  reg [12:0] frame;
  reg [8:0] dmask;
  integer k;
  integer m;
  // A frame starts on a tick, so its start bit lasts a whole bit time
  assign tx_pop = (tx_st_q == TX_IDLE) & txf_valid & tx_tick;
  always @* begin
    frame = 13'h1fff;
    dmask = 9'h000;
    frame[0] = 1'b0;
    for (k = 0; k < 9; k = k + 1) begin
      if (k < nbits) begin
        frame[k+1] = txf_q[k];
        dmask[k] = txf_q[k];
      end
    end
    if (par_en) begin
      frame[nbits+1] = (^dmask) ^ ~line_control[`BASC_LCR_EVEN];
    end
  end
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= 13'h1fff;
      tx_left_q <= 4'h0;
      tx_ph_q <= 4'h0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (txf_valid & tx_tick) begin
            tx_sh_q <= frame;
            tx_left_q <= tx_len;
            tx_ph_q <= 4'h0;
            tx_st_q <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tx_tick) begin
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == `BASC_OVS) begin
              tx_sh_q <= {1'b1, tx_sh_q[12:1]};
              tx_left_q <= tx_left_q - 4'h1;
              if (tx_left_q == 4'h1) begin
                tx_st_q <= TX_IDLE;
              end
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // ********************************
  // Receive engine
  // ********************************
  reg [3:0] rx_st_q;
  reg [3:0] rx_ph_q;
  reg [3:0] rx_n_q;
  reg [10:0] rx_sh_q;
  reg listen_q;
  reg ovr_q;
  reg perr_q;
  reg ferr_q;
  reg ctrl_q;
  reg amatch_q;
  reg [8:0] rd9;
  reg rx_par_bad;
  reg rx_stop_bad;
  reg is_addr;
  reg addr_hit;
  wire [7:0] receive_mode = cfg_q[`BASC_S_RMD];
  wire loop = cfg_q[`BASC_S_MCR][`BASC_MCR_LOOP];
  wire rx_in = loop ? tx_sh_q[0] : i_rxd;
  always @* begin
    rd9 = 9'h000;
    for (m = 0; m < 9; m = m + 1) begin
      if (m < nbits) begin
        rd9[m] = rx_sh_q[m];
      end
    end
    rx_par_bad = par_en & ((^rd9) ^ rx_sh_q[nbits] ^ ~line_control[`BASC_LCR_EVEN]);
    rx_stop_bad = ~rx_in;
    is_addr = receive_mode[`BASC_RMD_ADDR] & (nbits == 4'h9) & rd9[8];
    addr_hit = (rd9[7:0] == cfg_q[`BASC_S_ADDRESS_CHAR_ZERO]) | (rd9[7:0] == cfg_q[`BASC_S_ADDRESS_CHAR_ONE]);
    rx_word = {rx_stop_bad, rx_par_bad, rd9};
    rx_push = (rx_st_q == RX_DONE) & (is_addr ? addr_hit : listen_q);
  end
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rx_st_q <= RX_IDLE;
      rx_ph_q <= 4'h0;
      rx_n_q <= 4'h0;
      rx_sh_q <= 11'h000;
      listen_q <= 1'b1;
    end else begin
      case (rx_st_q)
        RX_IDLE: begin
          rx_ph_q <= 4'h0;
          rx_n_q <= 4'h0;
          if (~rx_in) begin
            rx_st_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_ph_q == `BASC_MID) begin
              rx_ph_q <= 4'h0;
              rx_st_q <= rx_in ? RX_IDLE : RX_BITS;
            end
          end
        end
        RX_BITS: begin
          if (rx_tick) begin
            rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_ph_q == `BASC_OVS) begin
              rx_n_q <= rx_n_q + 4'h1;
              if (rx_n_q == rx_len - 4'h1) begin
                rx_st_q <= RX_DONE;
              end else begin
                rx_sh_q[rx_n_q] <= rx_in;
              end
            end
          end
        end
        RX_DONE: begin
          if (is_addr) begin
            listen_q <= addr_hit;
          end
          rx_st_q <= RX_IDLE;
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // ********************************
  // Status flags; a new event wins over a read that clears it
  // ********************************
  wire rx_done = rx_st_q == RX_DONE;
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ovr_q <= 1'b0;
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
      ctrl_q <= 1'b0;
      amatch_q <= 1'b0;
    end else begin
      ovr_q <= (rx_push & ~rxf_ready) | (ovr_q & ~(rd_done & r_lsr));
      perr_q <= (rx_push & rx_par_bad) | (perr_q & ~(rd_done & r_lsr));
      ferr_q <= (rx_push & rx_stop_bad) | (ferr_q & ~(rd_done & r_lsr));
      ctrl_q <= (rx_done & receive_mode[`BASC_RMD_CTRL] & (rd9[7:0] == cfg_q[`BASC_S_ADDRESS_CHAR_ZERO]))
                | (ctrl_q & ~(rd_done & r_rst));
      amatch_q <= (rx_done & is_addr & addr_hit) | (amatch_q & ~(rd_done & r_rst));
    end
  end

  // ********************************
  // Service requests and read data
  // ********************************
  wire [7:0] general_enable = cfg_q[`BASC_S_GER];
  wire [7:0] fifo_mode = cfg_q[`BASC_S_FMD];
  wire rx_req = rxf_level > {1'b0, fifo_mode[5:4]};
  wire tx_req = txf_level <= {1'b0, fifo_mode[1:0]};
  wire tx_idle = (tx_st_q == TX_IDLE) & ~txf_valid;
  wire err_any = ovr_q | perr_q | ferr_q;
  wire irq_rx = general_enable[`BASC_GER_RX] & rx_req;
  wire irq_tx = general_enable[`BASC_GER_TX] & tx_req;
  wire irq_err = general_enable[`BASC_GER_ERR] & err_any;
  wire irq_any = irq_rx | irq_tx | irq_err;
  wire [1:0] src = irq_err ? 2'h3 : irq_rx ? 2'h2 : irq_tx ? 2'h1 : 2'h0;
  wire [7:0] gir = {1'b0, bank_q, 2'b00, src, ~irq_any};
  wire [7:0] line_status = {1'b0, tx_idle, ~txf_valid, 1'b0, ferr_q, perr_q, ovr_q, rxf_valid};
  wire [7:0] general_status = {3'h0, tx_idle, 2'h0, tx_req, rx_req};
  wire [7:0] rst_r = {6'h00, amatch_q, ctrl_q};
  wire [7:0] fifo_level = {1'b0, rxf_level, 1'b0, txf_level};
  wire [4:0] rk = {bank_q, i_addr};
  wire r_port = (i_addr == `BASC_A_DATA) & ((bank_q == `BASC_B0) & ~dls | (bank_q == `BASC_B1));
  reg [7:0] rdat;
  always @* begin
    rdat = 8'h00;
    if (i_addr == `BASC_A_BANK) begin
      rdat = gir;
    end else if (r_port) begin
      rdat = rxf_q[7:0];
    end else if (rk == {`BASC_B1, `BASC_A_AUX}) begin
      rdat = {5'h00, rxf_q[10:8]};
    end else if (rk == {`BASC_B1, `BASC_A_LINE}) begin
      rdat = `BASC_R_TIMER_STATUS;
    end else if (rk == {`BASC_B1, `BASC_A_MODE}) begin
      rdat = fifo_level;
    end else if (rk == {`BASC_B0, `BASC_A_STAT}) begin
      rdat = line_status;
    end else if (rk == {`BASC_B1, `BASC_A_STAT}) begin
      rdat = rst_r;
    end else if (rk == {`BASC_B1, `BASC_A_GEN}) begin
      rdat = general_status;
    end else if (r_map[5]) begin
      rdat = cfg_q[r_map[4:0]];
    end
  end

  // ********************************
  // Registered outputs
  // ********************************
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_data_q <= 8'h00;
      o_data_oe_q <= 1'b0;
      o_irq_q <= 1'b0;
      o_txd_q <= 1'b1;
    end else begin
      o_data_q <= rd_act ? rdat : 8'h00;
      o_data_oe_q <= rd_act;
      o_irq_q <= irq_any;
      if (cfg_q[`BASC_S_MCR][`BASC_MCR_ECHO]) begin
        o_txd_q <= i_rxd;
      end else begin
        o_txd_q <= loop | tx_sh_q[0];
      end
    end
  end
endmodule

// [sim/basc_props.sv]
// Port-level assertions for the banked serial controller
`timescale 1ns/1ps
module basc_props (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Host bus
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic [7:0] o_data_q,
  input wire logic o_data_oe_q,
  input wire logic i_read_strobe_low,
  input wire logic i_write_strobe_low,
  input wire logic i_select_low,
  input wire logic o_irq_q,
  // Serial line
  input wire logic i_rxd,
  input wire logic o_txd_q
);
  localparam int BIT_CLKS = 32;
  logic rd_act;
  logic [15:0] low_cnt_q;
  assign rd_act = !i_select_low && !i_read_strobe_low;
  // Length of the current low run on the serial output
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      low_cnt_q <= 16'h0000;
    end else if (o_txd_q) begin
      low_cnt_q <= 16'h0000;
    end else begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  sequence s_read_end;
    rd_act ##1 !rd_act;
  endsequence
  a_oe_follows_read: assert property (rd_act |=> o_data_oe_q)
    else $error("data bus not driven during read");
  a_oe_needs_read: assert property (o_data_oe_q |-> $past(rd_act))
    else $error("data bus driven without read");
  a_read_release: assert property (s_read_end |=> !o_data_oe_q)
    else $error("data bus held after read");
  a_data_quiet_idle: assert property (!rd_act |=> o_data_q == 8'h00)
    else $error("read data not zero outside read");
  a_txd_after_reset: assert property ($fell(i_rst) |-> o_txd_q)
    else $error("serial output not idle after reset");
  a_irq_after_reset: assert property ($fell(i_rst) |-> !o_irq_q)
    else $error("interrupt raised after reset");
  a_bit_time_exact: assert property ($rose(o_txd_q) |-> low_cnt_q % BIT_CLKS == 0 && low_cnt_q != 0)
    else $error("low run not a whole number of bit times");
  a_stop_bit_high: assert property ($rose(o_txd_q) |-> o_txd_q [*8])
    else $error("high level too short on serial output");
endmodule

// [sim/basc_serial_peer.sv]
// Remote serial partner: sends bytes on the receive line, decodes the transmit line
`timescale 1ns/1ps
module basc_serial_peer #(
  parameter int BIT_CLKS = 32
) (
  input wire logic i_mclk,
  input wire logic i_txd,
  output logic o_rxd
);
  logic [7:0] got[$];
  logic [7:0] sh;
  initial o_rxd = 1'b1;
  // Start bit, eight data bits LSB first, one stop bit
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge i_mclk);
      o_rxd = fr[i];
      repeat (BIT_CLKS - 1) @(negedge i_mclk);
    end
  endtask
  // Sample each data bit in its middle
  always begin
    @(negedge i_txd);
    repeat (BIT_CLKS / 2) @(posedge i_mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge i_mclk);
      sh[i] = i_txd;
    end
    repeat (BIT_CLKS) @(posedge i_mclk);
    got.push_back(sh);
  end
endmodule

// [sim/banked_async_serial_controller_test.sv]
// Self-checking testbench for the banked serial controller
`timescale 1ns/1ps
module banked_async_serial_controller_test;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_data = 8'h00;
  logic i_read_strobe_low = 1'b1;
  logic i_write_strobe_low = 1'b1;
  logic i_select_low = 1'b1;
  wire [7:0] o_data_q;
  wire o_data_oe_q;
  wire o_irq_q;
  wire o_txd_q;
  wire rxd;
  int error_cnt = 0;
  int tests_run = 0;
  logic [7:0] rv;
  logic [7:0] ev;
  logic [7:0] exp_q[$];
  // Entries: bank, divisor latch select, address, reset value
  logic [13:0] defs[18] = '{14'h0802, 14'h0900, 14'h0560, 14'h0600, 14'h0700, 14'h1712,
    14'h1400, 14'h1330, 14'h1500, 14'h240c, 14'h261e, 14'h2000, 14'h3805, 14'h3000,
    14'h34fc, 14'h350f, 14'h3384, 14'h3104};
  logic [4:0] rw_loc[4] = '{5'h07, 5'h06, 5'h1e, 5'h15};
  initial forever #20 i_mclk = ~i_mclk;
  basc_top dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_data(i_data),
    .o_data_q(o_data_q), .o_data_oe_q(o_data_oe_q), .i_read_strobe_low(i_read_strobe_low),
    .i_write_strobe_low(i_write_strobe_low), .i_select_low(i_select_low),
    .o_irq_q(o_irq_q), .i_rxd(rxd), .o_txd_q(o_txd_q));
  basc_serial_peer #(.BIT_CLKS(32)) ser_u (.i_mclk(i_mclk), .i_txd(o_txd_q), .o_rxd(rxd));
  function automatic logic [7:0] gir(input logic [1:0] b);
    return {1'b0, b, 5'h01};
  endfunction
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    i_addr = a;
    i_data = d;
    i_select_low = 1'b0;
    i_write_strobe_low = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_select_low = 1'b1;
    i_write_strobe_low = 1'b1;
    @(negedge i_mclk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    i_addr = a;
    i_select_low = 1'b0;
    i_read_strobe_low = 1'b0;
    repeat (2) @(negedge i_mclk);
    d = o_data_q;
    i_select_low = 1'b1;
    i_read_strobe_low = 1'b1;
    repeat (2) @(negedge i_mclk);
  endtask
  task automatic sel(input logic [1:0] b, input logic dls);
    wr(3'h2, 8'h00);
    wr(3'h3, {dls, 7'h03});
    wr(3'h2, {1'b0, b, 5'h00});
  endtask
  task automatic wait_rx;
    for (int n = 0; n < 100; n++) begin
      rd(3'h5, rv);
      if (rv[0]) break;
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #2400000;
    error_cnt++;
    $display("watchdog expired");
    close_out;
  end
  initial begin
    void'($urandom(99928));
    repeat (4) @(negedge i_mclk);
    i_rst = 1'b0;
    foreach (defs[k]) begin
      sel(defs[k][13:12], defs[k][11]);
      rd(defs[k][10:8], rv);
      chk("reset value", rv, defs[k][7:0]);
    end
    for (int b = 0; b < 4; b++) begin
      sel(2'(b), 1'b0);
      rd(3'h2, rv);
      chk("bank status", rv, gir(2'(b)));
    end
    foreach (rw_loc[k]) begin
      sel(rw_loc[k][4:3], 1'b0);
      ev = 8'($urandom);
      wr(rw_loc[k][2:0], ev);
      rd(rw_loc[k][2:0], rv);
      chk("rw register", rv, ev);
    end
    $display("register map done");
    for (int d = 1; d <= 4; d += 3) begin
      sel(2'h2, 1'b0);
      wr(3'h3, 8'((d - 1) << 6));
      sel(2'h0, 1'b0);
      ser_u.got.delete();
      exp_q.delete();
      for (int n = 0; n < d + 2; n++) begin
        rv = 8'($urandom);
        wr(3'h0, rv);
        if (n <= d) exp_q.push_back(rv);
      end
      repeat (340 * (d + 2)) @(negedge i_mclk);
      chk("tx frames", 8'(ser_u.got.size()), 8'(d + 1));
      foreach (exp_q[k]) chk("tx byte", ser_u.got[k], exp_q[k]);
    end
    $display("transmit depth done");
    wr(3'h1, 8'h01);
    repeat (3) begin
      ev = 8'($urandom);
      ser_u.send(ev);
      wait_rx();
      chk("irq raised", {7'h00, o_irq_q}, 8'h01);
      rd(3'h0, rv);
      chk("rx byte", rv, ev);
      repeat (2) @(negedge i_mclk);
      chk("irq cleared", {7'h00, o_irq_q}, 8'h00);
    end
    wr(3'h1, 8'h00);
    $display("receive done");
    wr(3'h4, 8'h10);
    ser_u.got.delete();
    ev = 8'($urandom);
    wr(3'h0, ev);
    repeat (100) @(negedge i_mclk);
    chk("line idle", {7'h00, o_txd_q}, 8'h01);
    wait_rx();
    rd(3'h0, rv);
    chk("loopback byte", rv, ev);
    chk("line frames", 8'(ser_u.got.size()), 8'h00);
    wr(3'h4, 8'h00);
    $display("loopback done");
    sel(2'h2, 1'b0);
    wr(3'h7, 8'h02);
    sel(2'h0, 1'b0);
    ev = 8'($urandom);
    wr(3'h7, ev);
    wr(3'h4, 8'h20);
    ser_u.got.delete();
    ser_u.send(ev);
    wait_rx();
    rd(3'h0, rv);
    chk("echo rx byte", rv, ev);
    chk("echo frames", 8'(ser_u.got.size()), 8'h01);
    chk("echo byte", ser_u.got[0], ev);
    sel(2'h1, 1'b0);
    rd(3'h5, rv);
    chk("control char", rv, 8'h01);
    $display("echo done");
    close_out;
  end
endmodule
bind basc_top basc_props props_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
  .i_data(i_data), .o_data_q(o_data_q), .o_data_oe_q(o_data_oe_q),
  .i_read_strobe_low(i_read_strobe_low), .i_write_strobe_low(i_write_strobe_low),
  .i_select_low(i_select_low), .o_irq_q(o_irq_q), .i_rxd(i_rxd), .o_txd_q(o_txd_q));
